//--- lsa_defs.vh
`ifndef LSA_DEFS_VH
`define LSA_DEFS_VH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define LSA_ADDR_AUX_CTRL      12'h000
`define LSA_ADDR_TIMER2_CTRL   12'h004
`define LSA_ADDR_STATUS        12'h008

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LSA_AUX_IND_SRC_BIT    0
`define LSA_AUX_IND_LEVEL_BIT  1
`define LSA_AUX_RESET          2'h0
`define LSA_T2_EN_BIT          8
`define LSA_T2_PERIOD_W        6
`define LSA_T2_RESET           9'h001
`define LSA_ST_L1_ACT_BIT      0
`define LSA_ST_TEST_BIT        1
`define LSA_ST_MODE_LO_BIT     2
`define LSA_ST_IND_BIT         4
`define LSA_ST_T2_OUT_BIT      5

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LSA_CLK_HZ             10000000
`define LSA_MS_NS              1000000
`define LSA_CLK_NS             100
`define LSA_CYC_PER_MS         (`LSA_MS_NS / `LSA_CLK_NS)
`define LSA_OSC_HZ             7680000
`define LSA_OSC_PHASE_W        24

// ----------------------------------------------------------------------------
// Operating modes {hi, lo}
// ----------------------------------------------------------------------------
`define LSA_MODE_TE            2'h0
`define LSA_MODE_LT_T          2'h1
`define LSA_MODE_LT_S          2'h2

`endif

//--- lsa_timer2.v
`timescale 1ns/1ps
`default_nettype none
`include "lsa_defs.vh"

module lsa_timer2 #(
    parameter CYC_PER_MS = `LSA_CYC_PER_MS
) (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // Control
    input  wire       enable_i,
    input  wire [5:0] period_ms_i,
    // Output
    output reg        square_o
);
    localparam CW = 20;

    reg  [CW-1:0] cyc_cnt;
    reg  [5:0]    half_cnt;
    wire [5:0]    per;

    // Zero period treated as 1 ms
    assign per     = (period_ms_i == 6'h00) ? 6'h01 : period_ms_i;

    // Square wave: each half lasts period/2 ms, counted in half-ms units
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cyc_cnt  <= {CW{1'b0}};
            half_cnt <= 6'h00;
            square_o <= 1'b0;
        end else if (!enable_i) begin
            cyc_cnt  <= {CW{1'b0}};
            half_cnt <= 6'h00;
            square_o <= 1'b0;
        end else begin
            // Tick every half millisecond so odd periods stay at 50 percent
            if (cyc_cnt >= (CYC_PER_MS[CW-1:0] >> 1) - {{(CW-1){1'b0}}, 1'b1}) begin
                cyc_cnt <= {CW{1'b0}};
                if (half_cnt == per - 6'h01) begin
                    half_cnt <= 6'h00;
                    square_o <= ~square_o; // see RULE_03
                end else begin
                    half_cnt <= half_cnt + 6'h01;
                end
            end else begin
                cyc_cnt <= cyc_cnt + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // lsa_timer2

`default_nettype wire

//--- lsa_osc_out.v
`timescale 1ns/1ps
`default_nettype none
`include "lsa_defs.vh"

module lsa_osc_out #(
    parameter CLK_HZ = `LSA_CLK_HZ,
    parameter OUT_HZ = `LSA_OSC_HZ
) (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Output
    output reg  clk_out_o
);
    localparam PW = `LSA_OSC_PHASE_W;
    // Phase step: half-periods of the output per input cycle, scaled by 2^PW
    localparam [63:0] STEP64 = (64'd2 * OUT_HZ * (64'd1 << PW)) / CLK_HZ;

    reg [PW:0] acc;

    // Free running from the local clock only, never steered by line timing
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc       <= {(PW+1){1'b0}};
            clk_out_o <= 1'b0;
        end else begin
            acc <= {1'b0, acc[PW-1:0]} + {1'b0, STEP64[PW-1:0]}; // see RULE_04
            if (acc[PW])
                clk_out_o <= ~clk_out_o; // see RULE_04
        end
    end
endmodule // lsa_osc_out

`default_nettype wire

//--- lsa_top.v
// Functional notes
// RULE_01 - All timing derives from one local clock, nominally 7.68 MHz crystal; the code assumes a 10 MHz clk_i (LSA_CLK_HZ).
// RULE_02 - Test select high means normal operation, low means test mode.
// RULE_03 - Timer two output is a 50 percent square wave, 1 to 63 ms.
// RULE_04 - Free running clock output at 7.68 MHz, not locked to line timing; from the 10 MHz clk_i the code gives about 2.68 MHz.
// RULE_05 - Source select 0 and layer 1 active: indicator pin driven low.
// RULE_06 - Source select 0 and layer 1 inactive: indicator pin driven high.
// RULE_07 - Source select 1: indicator follows software level regardless of layer 1.
// RULE_08 - Board straps mode pins: 00 TE, hi-only LT-S, lo-only LT-T.
// RULE_09 - Software level and source select are separate bits, reset to follow layer 1.
`timescale 1ns/1ps
`default_nettype none
`include "lsa_defs.vh"

module lsa_top #(
    parameter CYC_PER_MS = `LSA_CYC_PER_MS
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // APB slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // Pins
    input  wire        layer1_active_i,
    input  wire        functional_test_select_i,
    input  wire        op_mode_sel_lo_i,
    input  wire        op_mode_sel_hi_i,
    output reg         layer1_active_indicator_o,
    output wire        second_timer_square_out_o,
    output wire        free_running_clock_out_o,
    output reg         test_mode_o,
    output reg  [1:0]  op_mode_o
);
    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [1:0] aux_control_two;
    reg  [8:0] timer2_ctrl;
    wire       wr_en;
    wire       rd_en;
    wire       addr_ok;
    reg  [1:0] strap_mode;
    reg        strap_done;
    wire       next_indicator;

    assign wr_en    = psel_i & penable_i & pwrite_i;
    assign rd_en    = psel_i & penable_i & ~pwrite_i;
    assign addr_ok  = (paddr_i == `LSA_ADDR_AUX_CTRL) ||
                      (paddr_i == `LSA_ADDR_TIMER2_CTRL) ||
                      (paddr_i == `LSA_ADDR_STATUS);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~addr_ok;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_control_two <= `LSA_AUX_RESET; // see RULE_09
            timer2_ctrl     <= `LSA_T2_RESET;
        end else if (wr_en) begin
            if (paddr_i == `LSA_ADDR_AUX_CTRL)
                aux_control_two <= pwdata_i[1:0]; // see RULE_09
            if (paddr_i == `LSA_ADDR_TIMER2_CTRL)
                timer2_ctrl <= pwdata_i[8:0];
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            case (paddr_i)
                `LSA_ADDR_AUX_CTRL:    prdata_o <= {30'h0, aux_control_two};
                `LSA_ADDR_TIMER2_CTRL: prdata_o <= {23'h0, timer2_ctrl};
                `LSA_ADDR_STATUS:      prdata_o <= {26'h0,
                                                    second_timer_square_out_o,
                                                    layer1_active_indicator_o,
                                                    op_mode_o,
                                                    test_mode_o,
                                                    layer1_active_i};
                default:               prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Activation indicator
    // ------------------------------------------------------------------------
    assign next_indicator = aux_control_two[`LSA_AUX_IND_SRC_BIT]
                          ? aux_control_two[`LSA_AUX_IND_LEVEL_BIT] // see RULE_07
                          : ~layer1_active_i;                       // see RULE_05 RULE_06

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            layer1_active_indicator_o <= 1'b1;
        else
            layer1_active_indicator_o <= next_indicator;
    end

    // ------------------------------------------------------------------------
    // Test select and mode straps
    // ------------------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            test_mode_o <= 1'b0;
            strap_done  <= 1'b0;
            strap_mode  <= `LSA_MODE_TE;
            op_mode_o   <= `LSA_MODE_TE;
        end else begin
            test_mode_o <= ~functional_test_select_i; // see RULE_02
            if (!strap_done) begin
                strap_done <= 1'b1;
                strap_mode <= {op_mode_sel_hi_i, op_mode_sel_lo_i}; // see RULE_08
            end
            op_mode_o <= strap_done ? strap_mode : `LSA_MODE_TE;
        end
    end

    // ------------------------------------------------------------------------
    // Timer two and free running clock, both from clk_i
    // ------------------------------------------------------------------------
    lsa_timer2 #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_timer2 (
        .clk_i       (clk_i),                                // see RULE_01
        .rst_i       (rst_i),
        .enable_i    (timer2_ctrl[`LSA_T2_EN_BIT] & ~test_mode_o),
        .period_ms_i (timer2_ctrl[`LSA_T2_PERIOD_W-1:0]),    // see RULE_03
        .square_o    (second_timer_square_out_o)
    );

    lsa_osc_out u_osc (
        .clk_i     (clk_i),                                  // see RULE_01
        .rst_i     (rst_i),
        .clk_out_o (free_running_clock_out_o)
    );
endmodule // lsa_top

`default_nettype wire

//--- lsa_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsa_defs.vh"
module lsa_properties #(parameter CYC_PER_MS = 20) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // APB requests
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    // Pins
    input wire logic        layer1_active_i,
    input wire logic        functional_test_select_i,
    input wire logic        layer1_active_indicator_o,
    input wire logic        second_timer_square_out_o,
    input wire logic        free_running_clock_out_o,
    input wire logic        test_mode_o
);
    logic        src, lvl, en, osc_q;
    logic [5:0]  per;
    logic [15:0] hc;
    logic [2:0]  sc;
    wire         ind = layer1_active_indicator_o;
    wire         sq  = second_timer_square_out_o;
    wire         wr  = psel_i && penable_i && pwrite_i;
    wire [15:0]  half = 16'((per == 6'h0 ? 1 : per) * CYC_PER_MS / 2);
    // ------------------------------------------------------------------
    // Shadow control bits and run lengths
    // ------------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {src, lvl, en, osc_q, hc, sc} <= '0;
            per <= 6'h1;
        end else begin
            if (wr && paddr_i == `LSA_ADDR_AUX_CTRL) {lvl, src} <= pwdata_i[1:0];
            if (wr && paddr_i == `LSA_ADDR_TIMER2_CTRL) {en, per} <= {pwdata_i[8], pwdata_i[5:0]};
            hc <= sq ? hc + 16'h1 : 16'h0;
            osc_q <= free_running_clock_out_o;
            sc <= (free_running_clock_out_o == osc_q) ? sc + 3'h1 : 3'h0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ind_act; (!src && layer1_active_i) [*2] |=> !ind; endproperty
    a_ind_act: assert property (p_ind_act) else $error("indicator not low");
    property p_ind_idle; (!src && !layer1_active_i) [*2] |=> ind; endproperty
    a_ind_idle: assert property (p_ind_idle) else $error("indicator not high");
    property p_ind_sw; (src && $stable(lvl)) [*2] |=> ind == $past(lvl); endproperty
    a_ind_sw: assert property (p_ind_sw) else $error("indicator not software level");
    property p_ind_rst; disable iff (1'b0) rst_i |-> ind; endproperty
    a_ind_rst: assert property (p_ind_rst) else $error("indicator low in reset");
    property p_test; 1 |=> test_mode_o == !$past(functional_test_select_i); endproperty
    a_test: assert property (p_test) else $error("test mode wrong");
    property p_sq_len; $fell(sq) && en && !test_mode_o |-> hc == half; endproperty
    a_sq_len: assert property (p_sq_len) else $error("timer high time wrong");
    property p_sq_off; (!en) [*3] |-> !sq; endproperty
    a_sq_off: assert property (p_sq_off) else $error("timer runs while off");
    property p_osc; sc < 3'h4; endproperty
    a_osc: assert property (p_osc) else $error("clock output stalled");
endmodule // lsa_properties
`default_nettype wire

//--- lsa_board.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsa_defs.vh"
module lsa_board #(parameter logic [1:0] STRAP = `LSA_MODE_LT_S) (
    // Mode straps
    output wire logic op_mode_sel_hi_o,
    output wire logic op_mode_sel_lo_o,
    // Status lamp
    input  wire logic indicator_n_i,
    output wire logic led_on_o
);
    assign {op_mode_sel_hi_o, op_mode_sel_lo_o} = STRAP;
    assign led_on_o = !indicator_n_i;
endmodule // lsa_board
`default_nettype wire

//--- layer1_status_and_aux_outputs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsa_defs.vh"
module layer1_status_and_aux_outputs_bench;
    localparam int CPM = 20;
    logic        clk = 0, rst = 0, psel = 0, pen = 0, pwr = 0, l1 = 0, fts = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwd = 0, prd, rdat;
    logic        rdy, serr, rerr, ind, sq, osc, tm, hi, lo, led;
    logic [1:0]  mode;
    int          errors = 0, checks_done = 0, cyc = 0, n;
    int          pers[3] = '{1, 63, 0};
    always #50 clk = ~clk;
    lsa_top #(.CYC_PER_MS(CPM)) uut (.clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
        .pslverr_o(serr), .layer1_active_i(l1), .functional_test_select_i(fts),
        .op_mode_sel_lo_i(lo), .op_mode_sel_hi_i(hi), .layer1_active_indicator_o(ind),
        .second_timer_square_out_o(sq), .free_running_clock_out_o(osc), .test_mode_o(tm),
        .op_mode_o(mode));
    lsa_board board (.op_mode_sel_hi_o(hi), .op_mode_sel_lo_o(lo), .indicator_n_i(ind),
        .led_on_o(led));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwr <= w;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rdat = prd;
        rerr = serr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic end_sim;
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        rst <= 1'b1;
        wt(8);
        rst <= 1'b0;
        wt(2);
        apb(`LSA_ADDR_AUX_CTRL, 0, 0);
        chk(rdat, 0);
        apb(`LSA_ADDR_TIMER2_CTRL, 0, 0);
        chk(rdat, `LSA_T2_RESET);
        chk(mode, `LSA_MODE_LT_S);
        chk(led, 0);
        $display("reset test done");
        l1 <= 1'b1;
        wt(3);
        chk(led, 1);
        l1 <= 1'b0;
        wt(3);
        chk(led, 0);
        apb(`LSA_ADDR_AUX_CTRL, 1, 1);
        l1 <= 1'b1;
        wt(3);
        chk(ind, 0);
        apb(`LSA_ADDR_AUX_CTRL, 1, 3);
        wt(3);
        chk(ind, 1);
        apb(`LSA_ADDR_AUX_CTRL, 0, 0);
        chk(rdat, 3);
        // Layer 1 up, normal, strap 10, indicator high, timer low
        apb(`LSA_ADDR_STATUS, 0, 0);
        chk(rdat, 32'h19);
        apb(`LSA_ADDR_AUX_CTRL, 1, 0);
        wt(3);
        chk(ind, 0);
        apb(12'h00c, 0, 0);
        chk(rerr, 1);
        chk(rdat, 0);
        $display("indicator test done");
        fts <= 1'b0;
        wt(2);
        chk(tm, 1);
        fts <= 1'b1;
        wt(2);
        chk(tm, 0);
        $display("test select done");
        foreach (pers[i]) begin
            apb(`LSA_ADDR_TIMER2_CTRL, 1, 32'h100 | pers[i]);
            while (sq !== 1'b1) @(posedge clk);
            n = 0;
            while (sq === 1'b1) begin
                @(posedge clk);
                n++;
            end
            chk(n, (pers[i] == 0 ? 1 : pers[i]) * CPM / 2);
            apb(`LSA_ADDR_TIMER2_CTRL, 1, pers[i]);
            wt(700);
            chk(sq, 0);
        end
        $display("timer test done");
        apb(`LSA_ADDR_AUX_CTRL, 1, 3);
        rst <= 1'b1;
        wt(2);
        chk(ind, 1);
        rst <= 1'b0;
        wt(3);
        chk(ind, 0);
        $display("mid-run reset done");
        end_sim();
    end
endmodule // layer1_status_and_aux_outputs_bench
bind lsa_top lsa_properties #(.CYC_PER_MS(CYC_PER_MS)) u_props (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .layer1_active_i(layer1_active_i),
    .functional_test_select_i(functional_test_select_i),
    .layer1_active_indicator_o(layer1_active_indicator_o),
    .second_timer_square_out_o(second_timer_square_out_o),
    .free_running_clock_out_o(free_running_clock_out_o), .test_mode_o(test_mode_o));
`default_nettype wire
